// ### inc/sld_defs.vh
`ifndef SLD_DEFS_VH
`define SLD_DEFS_VH

// Register indices; byte address is four times the index
`define SLD_IDX_THRESHOLD   20'hf0d0
`define SLD_IDX_ENRESULT    20'hf0d1
`define SLD_IDX_WORDVIEW    20'hf0d2
`define SLD_IDX_IRQ_STATUS  20'hf0d3
`define SLD_IDX_IRQ_MASK    20'hf0d4

// Byte addresses on the register bus
`define SLD_ADDR_THRESHOLD  20'h3c340
`define SLD_ADDR_ENRESULT   20'h3c344
`define SLD_ADDR_WORDVIEW   20'h3c348
`define SLD_ADDR_IRQ_STATUS 20'h3c34c
`define SLD_ADDR_IRQ_MASK   20'h3c350

// Field positions
`define SLD_THR_MSB         3
`define SLD_BIT_DET_ON      0
`define SLD_BIT_LOW_FLAG    1
`define SLD_IRQ_LOW_RISE    0
`define SLD_IRQ_SETTLED     1
`define SLD_BIT_SETTLED     2

// Reset values
`define SLD_RST_THRESHOLD   4'h0
`define SLD_RST_ENRESULT    1'b0
`define SLD_RST_IRQ         2'h0

// Settling interval: 1000 us at 25 MHz
`define SLD_SETTLE_US       1000
`define SLD_CLK_MHZ         25
`define SLD_SETTLE_CYCLES   (`SLD_SETTLE_US * `SLD_CLK_MHZ)

// Bus responses
`define SLD_RESP_OKAY       2'h0
`define SLD_RESP_SLVERR     2'h2

`endif

// ### hdl/sld_sync.v
`timescale 1ns/100ps
`default_nettype none

module sld_sync #(
    parameter WIDTH = 1
) (
    // Clock and reset
    input  wire             aclk,
    input  wire             aresetn,
    // Asynchronous level in, synchronised level out
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta_ff;
    reg [WIDTH-1:0] sync_ff;

    // First stage feeds only the second; nothing else looks at it
    always @(posedge aclk) begin
        if (!aresetn) begin
            meta_ff <= {WIDTH{1'b0}};
            sync_ff <= {WIDTH{1'b0}};
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;

endmodule // sld_sync

`default_nettype wire

// ### hdl/sld_settle.v
`timescale 1ns/100ps
`default_nettype none

module sld_settle #(
    parameter CYCLES = 25000,
    parameter CNT_W  = 16
) (
    // Clock and reset
    input  wire aclk,
    input  wire aresetn,
    // Detector power state
    input  wire enable,
    // Settling state
    output wire settled,
    output wire done_pulse
);

    // Last count held as an integer first, then cut to the counter width on purpose
    localparam integer     LAST_I = CYCLES - 1;
    localparam [CNT_W-1:0] LAST   = LAST_I[CNT_W-1:0];

    reg [CNT_W-1:0] cnt_ff;
    reg             settled_ff;
    reg             done_ff;

    // Count from power-up; any switch-off restarts the interval
    always @(posedge aclk) begin
        if (!aresetn) begin
            cnt_ff     <= {CNT_W{1'b0}};
            settled_ff <= 1'b0;
            done_ff    <= 1'b0;
        end else if (!enable) begin
            cnt_ff     <= {CNT_W{1'b0}};
            settled_ff <= 1'b0;
            done_ff    <= 1'b0;
        end else if (!settled_ff) begin
            cnt_ff     <= cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
            settled_ff <= (cnt_ff == LAST);
            done_ff    <= (cnt_ff == LAST);
        end else begin
            done_ff    <= 1'b0;
        end
    end

    assign settled    = settled_ff;
    assign done_pulse = done_ff;

endmodule // sld_settle

`default_nettype wire

// ### hdl/sld_top.v
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "sld_defs.vh"

module sld_top #(
    parameter SETTLE_CYCLES = `SLD_SETTLE_CYCLES,
    parameter CNT_W         = 16
) (
    // Clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // Write address channel
    input  wire [19:0] s_axi_awaddr,
    input  wire [2:0]  s_axi_awprot,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    // Write data channel
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    // Write response channel
    output wire [1:0]  s_axi_bresp,
    output wire        s_axi_bvalid,
    input  wire        s_axi_bready,
    // Read address channel
    input  wire [19:0] s_axi_araddr,
    input  wire [2:0]  s_axi_arprot,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    // Read data channel
    output wire [31:0] s_axi_rdata,
    output wire [1:0]  s_axi_rresp,
    output wire        s_axi_rvalid,
    input  wire        s_axi_rready,
    // Analog comparator and level selector
    input  wire        cmp_supply_low_async,
    output wire [3:0]  trip_voltage_code,
    output wire        detector_pwr_on,
    // Interrupt
    output wire        irq
);

    // Bus channel state
    reg        awready_ff;
    reg        wready_ff;
    reg        aw_held_ff;
    reg        w_held_ff;
    reg [19:0] awaddr_ff;
    reg [31:0] wdata_ff;
    reg [3:0]  wstrb_ff;
    reg        bvalid_ff;
    reg [1:0]  bresp_ff;
    reg        arready_ff;
    reg        rvalid_ff;
    reg [31:0] rdata_ff;
    reg [1:0]  rresp_ff;

    // Detector registers
    reg [3:0]  threshold_code_ff;
    reg        detector_on_ff;
    reg        supply_low_flag_ff;
    reg [1:0]  irq_status_ff;
    reg [1:0]  irq_mask_ff;
    reg        irq_ff;
    reg [1:0]  on_dly_ff;

    // Next values
    reg [3:0]  nxt_threshold_code;
    reg        nxt_detector_on;
    reg        nxt_supply_low_flag;
    reg [1:0]  nxt_irq_status;
    reg [1:0]  nxt_irq_mask;
    reg [1:0]  irq_clear;
    reg [7:0]  thr_merged;

    wire       cmp_sync;
    wire       settled;
    wire       settle_done;
    wire       wr_fire;
    wire       rd_take;
    wire [1:0] irq_events;

    // Byte lanes of one register byte, merged under its strobe
    function [7:0] lane_merge;
        input [7:0] old_val;
        input [7:0] new_val;
        input       strobe;
        begin
            lane_merge = strobe ? new_val : old_val;
        end
    endfunction

    // Read value for a byte address; unmapped reads as zero
    function [31:0] rd_mux;
        input [19:0] addr;
        input [3:0]  thr;
        input        en;
        input        flag;
        input        stl;
        input [1:0]  sts;
        input [1:0]  msk;
        begin
            case (addr)
                `SLD_ADDR_THRESHOLD:  rd_mux = {28'h0000000, thr};
                `SLD_ADDR_ENRESULT:   rd_mux = {29'h00000000, stl, flag, en};
                `SLD_ADDR_WORDVIEW:   rd_mux = {16'h0000, 6'h00, flag, en, 4'h0, thr};
                `SLD_ADDR_IRQ_STATUS: rd_mux = {30'h00000000, sts};
                `SLD_ADDR_IRQ_MASK:   rd_mux = {30'h00000000, msk};
                default:              rd_mux = 32'h00000000;
            endcase
        end
    endfunction

    // Whether a byte address is mapped
    function addr_ok;
        input [19:0] addr;
        begin
            case (addr)
                `SLD_ADDR_THRESHOLD,
                `SLD_ADDR_ENRESULT,
                `SLD_ADDR_WORDVIEW,
                `SLD_ADDR_IRQ_STATUS,
                `SLD_ADDR_IRQ_MASK:   addr_ok = 1'b1;
                default:              addr_ok = 1'b0;
            endcase
        end
    endfunction

    // Comparator output is asynchronous to aclk
    sld_sync #(
        .WIDTH    (1)
    ) u_cmp_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in (cmp_supply_low_async),
        .sync_out (cmp_sync)
    );

    // Settling interval after power-up, reported as status and event
    sld_settle #(
        .CYCLES     (SETTLE_CYCLES),
        .CNT_W      (CNT_W)
    ) u_settle (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .enable     (detector_on_ff),
        .settled    (settled),
        .done_pulse (settle_done)
    );

    assign wr_fire = aw_held_ff & w_held_ff & ~bvalid_ff;
    assign rd_take = s_axi_arvalid & arready_ff;

    // Address and data are taken independently, in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
            aw_held_ff <= 1'b0;
            w_held_ff  <= 1'b0;
            awaddr_ff  <= 20'h00000;
            wdata_ff   <= 32'h00000000;
            wstrb_ff   <= 4'h0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= `SLD_RESP_OKAY;
        end else begin
            if (wr_fire) begin
                aw_held_ff <= 1'b0;
            end else if (s_axi_awvalid && awready_ff) begin
                aw_held_ff <= 1'b1;
                awaddr_ff  <= s_axi_awaddr;
                awready_ff <= 1'b0;
            end else if (!aw_held_ff && !bvalid_ff) begin
                awready_ff <= 1'b1;
            end
            if (wr_fire) begin
                w_held_ff <= 1'b0;
            end else if (s_axi_wvalid && wready_ff) begin
                w_held_ff <= 1'b1;
                wdata_ff  <= s_axi_wdata;
                wstrb_ff  <= s_axi_wstrb;
                wready_ff <= 1'b0;
            end else if (!w_held_ff && !bvalid_ff) begin
                wready_ff <= 1'b1;
            end
            // Response only after both halves; unmapped gets an error
            if (wr_fire) begin
                bvalid_ff <= 1'b1;
                bresp_ff  <= addr_ok(awaddr_ff) ? `SLD_RESP_OKAY : `SLD_RESP_SLVERR;
            end else if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // Read channel: one read at a time, answer one cycle after address
    always @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h00000000;
            rresp_ff   <= `SLD_RESP_OKAY;
        end else if (rvalid_ff) begin
            if (s_axi_rready) begin
                rvalid_ff  <= 1'b0;
                arready_ff <= 1'b1;
            end
        end else if (rd_take) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b1;
            rdata_ff   <= rd_mux(s_axi_araddr, threshold_code_ff, detector_on_ff,
                                 supply_low_flag_ff, settled, irq_status_ff, irq_mask_ff);
            rresp_ff   <= addr_ok(s_axi_araddr) ? `SLD_RESP_OKAY : `SLD_RESP_SLVERR;
        end else begin
            arready_ff <= 1'b1;
        end
    end

    // Register writes; the flag bit has no write path
    always @* begin
        nxt_threshold_code = threshold_code_ff;
        nxt_detector_on    = detector_on_ff;
        nxt_irq_mask       = irq_mask_ff;
        irq_clear          = 2'h0;
        thr_merged         = lane_merge({4'h0, threshold_code_ff}, wdata_ff[7:0], wstrb_ff[0]);
        if (wr_fire) begin
            case (awaddr_ff)
                `SLD_ADDR_THRESHOLD: begin
                    nxt_threshold_code = thr_merged[3:0];
                end
                `SLD_ADDR_ENRESULT: begin
                    if (wstrb_ff[0]) begin
                        nxt_detector_on = wdata_ff[`SLD_BIT_DET_ON];
                    end
                end
                `SLD_ADDR_WORDVIEW: begin
                    nxt_threshold_code = thr_merged[3:0];
                    if (wstrb_ff[1]) begin
                        nxt_detector_on = wdata_ff[8 + `SLD_BIT_DET_ON];
                    end
                end
                `SLD_ADDR_IRQ_STATUS: begin
                    if (wstrb_ff[0]) begin
                        irq_clear = wdata_ff[1:0];
                    end
                end
                `SLD_ADDR_IRQ_MASK: begin
                    if (wstrb_ff[0]) begin
                        nxt_irq_mask = wdata_ff[1:0];
                    end
                end
                default: begin
                    nxt_irq_mask = irq_mask_ff;
                end
            endcase
        end
    end

    // Flag follows the comparator while powered, holds when off; the two samples
    // in the synchroniser right after power-up are from the unpowered side, so skip them
    always @* begin
        nxt_supply_low_flag = supply_low_flag_ff;
        if (detector_on_ff && on_dly_ff == 2'h3) begin
            nxt_supply_low_flag = cmp_sync;
        end
    end

    // Events: supply dropped below threshold, settling interval elapsed
    assign irq_events[`SLD_IRQ_LOW_RISE] = nxt_supply_low_flag & ~supply_low_flag_ff;
    assign irq_events[`SLD_IRQ_SETTLED]  = settle_done;

    // A new event beats a clear in the same cycle
    always @* begin
        nxt_irq_status = (irq_status_ff & ~irq_clear) | irq_events;
    end

    // State registers
    always @(posedge aclk) begin
        if (!aresetn) begin
            threshold_code_ff  <= `SLD_RST_THRESHOLD;
            detector_on_ff     <= `SLD_RST_ENRESULT;
            supply_low_flag_ff <= `SLD_RST_ENRESULT;
            irq_status_ff      <= `SLD_RST_IRQ;
            irq_mask_ff        <= `SLD_RST_IRQ;
            irq_ff             <= 1'b0;
            on_dly_ff          <= 2'h0;
        end else begin
            on_dly_ff          <= {on_dly_ff[0], detector_on_ff};
            threshold_code_ff  <= nxt_threshold_code;
            detector_on_ff     <= nxt_detector_on;
            supply_low_flag_ff <= nxt_supply_low_flag;
            irq_status_ff      <= nxt_irq_status;
            irq_mask_ff        <= nxt_irq_mask;
            irq_ff             <= |(nxt_irq_status & nxt_irq_mask);
        end
    end

    // Bus outputs, all registered
    assign s_axi_awready = awready_ff;
    assign s_axi_wready  = wready_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;

    // Code is passed as written; changing it while on is not guarded here
    assign trip_voltage_code = threshold_code_ff;
    // Power is cut whenever the enable bit is low
    assign detector_pwr_on   = detector_on_ff;
    assign irq               = irq_ff;

endmodule // sld_top

`default_nettype wire

// ### bench/sld_cmp_model.sv
`timescale 1ns/100ps
`default_nettype none

module sld_cmp_model (
    // Level selector and power from the block
    input  wire logic [3:0]  trip_voltage_code,
    input  wire logic        detector_pwr_on,
    // Supply seen by the ladder, in millivolts
    input  wire logic [11:0] supply_mv,
    // Comparator result: while powered, high when supply is below the trip level; inverted while unpowered
    output var  logic        cmp_supply_low_async
);
    logic [11:0] trip_mv;

    // Ladder: fine steps low down, coarse steps above, two wide top steps
    always @* begin
        if (trip_voltage_code < 4'h4) begin
            trip_mv = 12'd1350 + 12'd50 * trip_voltage_code;
        end else if (trip_voltage_code < 4'he) begin
            trip_mv = 12'd1200 + 12'd100 * trip_voltage_code;
        end else begin
            trip_mv = (trip_voltage_code == 4'he) ? 12'd2700 : 12'd2900;
        end
    end

    // Unpowered output is meaningless; it shows the wrong answer so stale samples show up
    always @* begin
        if (detector_pwr_on) begin
            cmp_supply_low_async = (supply_mv < trip_mv);
        end else begin
            cmp_supply_low_async = !(supply_mv < trip_mv);
        end
    end
endmodule // sld_cmp_model

`default_nettype wire

// ### bench/sld_assertions.sv
`timescale 1ns/100ps
`default_nettype none

module sld_assertions (
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Register bus
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // Analog side and interrupt
    input wire logic [3:0]  trip_voltage_code,
    input wire logic        detector_pwr_on,
    input wire logic        irq
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Outputs come out of reset cleared
    a_reset_clear: assert property (aresetn && !$past(aresetn) |->
        trip_voltage_code == 4'h0 && !detector_pwr_on && !irq)
        else $error("outputs not cleared after reset");
    // Analog controls move only with a completed register write
    a_code_on_write: assert property ($changed(trip_voltage_code) |-> $rose(s_axi_bvalid))
        else $error("threshold code moved without a write");
    a_pwr_on_write: assert property ($changed(detector_pwr_on) |-> $rose(s_axi_bvalid))
        else $error("detector power moved without a write");
    // A powered-down detector cannot raise an event
    a_irq_cause: assert property ($rose(irq) |->
        $rose(s_axi_bvalid) || detector_pwr_on || $past(detector_pwr_on))
        else $error("interrupt rose with detector off");
    // Bus answers hold until taken; a write answers after both halves, a read the next cycle
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read data dropped early");
    a_b_after_both: assert property ($rose(s_axi_bvalid) |->
        !s_axi_awready && !s_axi_wready)
        else $error("write response before address and data taken");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid && !s_axi_arready)
        else $error("read not answered next cycle");

    c_irq: cover property ($rose(irq));
    c_pwr: cover property ($rose(detector_pwr_on));
    c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule // sld_assertions

bind sld_top sld_assertions chk_u (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .trip_voltage_code(trip_voltage_code),
    .detector_pwr_on(detector_pwr_on), .irq(irq)
);

`default_nettype wire

// ### bench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "sld_defs.vh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
    $display("ERROR %s exp %h got %h", nm, e, g); end end

module tb_top;
    // Clock, reset, bus and supply
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [19:0] awaddr = 20'h0, araddr = 20'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0]  wstrb = 4'h0, code;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, pwr, irq, cmp_low;
    logic [1:0]  bresp, rresp;
    logic [11:0] supply_mv = 12'd1750;
    int          n_mismatch = 0, compares = 0;

    always #20 aclk = ~aclk;

    sld_top #(.SETTLE_CYCLES(12), .CNT_W(16)) dut_u (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cmp_supply_low_async(cmp_low),
        .trip_voltage_code(code), .detector_pwr_on(pwr), .irq(irq)
    );

    sld_cmp_model cmp_u (
        .trip_voltage_code(code), .detector_pwr_on(pwr), .supply_mv(supply_mv),
        .cmp_supply_low_async(cmp_low)
    );

    task automatic close_out;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Bounded wait on one handshake; a hang ends the run
    task automatic give_up(input int n);
        if (n >= 64) begin
            n_mismatch++;
            close_out;
        end
    endtask

    // Write: address and data offered together, bready held until the answer
    task automatic wr(input logic [19:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 64);
        give_up(n);
        bready <= 1'b0;
        `CHK("bresp", er, bresp);
        @(posedge aclk);
    endtask

    // Read and compare; idle edge after so strobes never toggle twice in a step
    task automatic rd(input logic [19:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 64);
        give_up(n);
        rready <= 1'b0;
        `CHK("rdata", ed, rdata);
        `CHK("rresp", er, rresp);
        @(posedge aclk);
    endtask

    task automatic wait_irq;
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 64) begin
            @(posedge aclk);
            n++;
        end
        give_up(n);
    endtask

    task automatic tend(input string nm);
        $display("test %s done", nm);
    endtask

    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        `CHK("code", 4'h0, code);
        `CHK("pwr", 1'b0, pwr);
        rd(`SLD_ADDR_THRESHOLD, 32'h0, 2'h0);
        rd(`SLD_ADDR_ENRESULT, 32'h0, 2'h0);
        tend("reset");
        // Every code reaches the selector unchanged; upper bits read zero
        for (int c = 0; c < 16; c++) begin
            wr(`SLD_ADDR_THRESHOLD, {28'hfffffff, c[3:0]}, 4'h1, 2'h0);
            `CHK("code", c[3:0], code);
            rd(`SLD_ADDR_THRESHOLD, {28'h0, c[3:0]}, 2'h0);
        end
        wr(`SLD_ADDR_THRESHOLD, 32'h3, 4'h0, 2'h0);
        `CHK("code", 4'hf, code);
        tend("codes");
        // Measurement: code 5 trips at 1700 mV, supply sits just above
        wr(`SLD_ADDR_THRESHOLD, 32'h5, 4'h1, 2'h0);
        wr(`SLD_ADDR_IRQ_MASK, 32'h2, 4'h1, 2'h0);
        wr(`SLD_ADDR_ENRESULT, 32'h3, 4'h1, 2'h0);
        `CHK("pwr", 1'b1, pwr);
        rd(`SLD_ADDR_ENRESULT, 32'h1, 2'h0);
        wait_irq();
        rd(`SLD_ADDR_ENRESULT, 32'h5, 2'h0);
        wr(`SLD_ADDR_IRQ_STATUS, 32'h2, 4'h1, 2'h0);
        `CHK("irq", 1'b0, irq);
        wr(`SLD_ADDR_IRQ_MASK, 32'h1, 4'h1, 2'h0);
        supply_mv <= 12'd1650;
        repeat (2) @(posedge aclk);
        `CHK("irq", 1'b0, irq);
        wait_irq();
        rd(`SLD_ADDR_ENRESULT, 32'h7, 2'h0);
        wr(`SLD_ADDR_IRQ_STATUS, 32'h1, 4'h1, 2'h0);
        `CHK("irq", 1'b0, irq);
        wr(`SLD_ADDR_ENRESULT, 32'h0, 4'h1, 2'h0);
        `CHK("pwr", 1'b0, pwr);
        supply_mv <= 12'd1750;
        rd(`SLD_ADDR_ENRESULT, 32'h2, 2'h0);
        tend("measure");
        // Word view: code 9 trips at 2100 mV, so the flag reads low supply
        wr(`SLD_ADDR_WORDVIEW, 32'h109, 4'h3, 2'h0);
        `CHK("code", 4'h9, code);
        `CHK("pwr", 1'b1, pwr);
        repeat (4) @(posedge aclk);
        rd(`SLD_ADDR_WORDVIEW, 32'h309, 2'h0);
        wr(`SLD_ADDR_WORDVIEW, 32'h0, 4'h2, 2'h0);
        `CHK("pwr", 1'b0, pwr);
        rd(`SLD_ADDR_THRESHOLD, 32'h9, 2'h0);
        tend("word");
        // Unmapped address answers with an error and no data
        rd(20'h3c360, 32'h0, 2'h2);
        wr(20'h3c360, 32'hff, 4'hf, 2'h2);
        rd(`SLD_ADDR_THRESHOLD, 32'h9, 2'h0);
        tend("unmapped");
        close_out();
    end
endmodule // tb_top

`default_nettype wire
